// >>> include/rhsp_fifo_if.sv
// Valid/ready carrier between the port and its load buffer.
`timescale 1ns/10ps
`default_nettype none
interface rhsp_fifo_if #(parameter int WIDTH = 8) ();
   logic             in_valid;
   logic             in_ready;
   logic [WIDTH-1:0] in_data;
   logic             out_valid;
   logic             out_ready;
   logic [WIDTH-1:0] out_data;
   modport buffer (input in_valid, input in_data, input out_ready,
                   output in_ready, output out_valid, output out_data);
   modport source (output in_valid, output in_data, input in_ready);
   modport sink   (input out_valid, input out_data, output out_ready);
endinterface : rhsp_fifo_if
`default_nettype wire

// >>> include/rhsp_pkg.sv
// Types of the reader host serial port.
`default_nettype none
package rhsp_pkg;
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_ctrl = 2'b01,
      st_data = 2'b11,
      st_halt = 2'b10
   } rhsp_state_t;
   typedef logic [7:0] rhsp_byte_t;
   typedef logic [5:0] rhsp_addr_t;
endpackage : rhsp_pkg
`default_nettype wire

// >>> include/rhsp_regs.svh
// Constants of the reader host serial port.
`ifndef RHSP_REGS_SVH
`define RHSP_REGS_SVH

`define RHSP_BYTE_BITS   8
`define RHSP_BIT_LAST    3'h7
`define RHSP_FIFO_DEPTH  16
`define RHSP_MODE_WRITE  2'h0
`define RHSP_MODE_READ   2'h1
`define RHSP_MODE_FIFO   2'h2
`define RHSP_MODE_CMD    2'h3
`define RHSP_FIFO_LOAD   6'h00
`define RHSP_FIFO_READ   6'h3F
`define RHSP_ADDR_INC    6'h01
`define RHSP_MAP_LAST    6'h3D
`define RHSP_RO_FIRST    6'h38
`define RHSP_LOAD_MAX    6'h20

`endif

// >>> rtl/rhsp_fifo.sv
// Synchronous FIFO with registered read data and registered flags.
`timescale 1ns/10ps
`default_nettype none
module rhsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic        clock,
   input wire logic        srst,
   // Both sides
   rhsp_fifo_if.buffer     f
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr, next_wptr, rptr, next_rptr;
   logic [AW:0]      count, next_count;
   logic             ready, next_ready;
   logic             out_valid, next_out_valid;
   logic [WIDTH-1:0] out_data, next_out_data;
   logic             push, pop;

   assign f.in_ready  = ready;
   assign f.out_valid = out_valid;
   assign f.out_data  = out_data;

   always_comb begin
      push           = f.in_valid & ready;
      pop            = (count != '0) & (~out_valid | f.out_ready);
      next_wptr      = push ? wptr + AW'(1) : wptr;
      next_rptr      = pop ? rptr + AW'(1) : rptr;
      next_count     = count + (AW+1)'(push) - (AW+1)'(pop);
      next_out_data  = pop ? mem[rptr] : out_data;
      next_out_valid = pop | (out_valid & ~f.out_ready);
      // Ready is held in a flop so the filling side sees a clean flag.
      // The output register counts toward the depth, so at most DEPTH words wait.
      next_ready     = ((next_count + (AW+1)'(next_out_valid)) != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wptr] <= f.in_data;
      end
      if (srst) begin
         wptr      <= '0;
         rptr      <= '0;
         count     <= '0;
         ready     <= 1'b1;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         wptr      <= next_wptr;
         rptr      <= next_rptr;
         count     <= next_count;
         ready     <= next_ready;
         out_valid <= next_out_valid;
         out_data  <= next_out_data;
      end
   end
endmodule : rhsp_fifo
`default_nettype wire

// >>> rtl/rhsp_port.sv
// Serial slave port that lets a host reach registers, FIFOs and commands.
`timescale 1ns/10ps
`default_nettype none
`include "rhsp_regs.svh"
module rhsp_port #(
   parameter int                  FIFO_DEPTH = `RHSP_FIFO_DEPTH,
   parameter logic [5:0]          MAP_LAST   = `RHSP_MAP_LAST,
   parameter logic [5:0]          RO_FIRST   = `RHSP_RO_FIRST
) (
   // Core clock and reset
   input  wire logic              clock,
   input  wire logic              srst,
   // Serial pins
   input  wire logic              serial_select,
   input  wire logic              serial_clock,
   input  wire logic              serial_in,
   output logic                   serial_out,
   output logic                   serial_out_en,
   // Enable pin and interrupt pin
   input  wire logic              external_enable_pin,
   output logic                   interrupt_request,
   // Core status into the port and run enable out
   input  wire logic              run_enable_bit,
   input  wire logic              irq_pending,
   output logic                   run_enable,
   // Register write strobe
   output logic                   wr_valid,
   output logic [5:0]             wr_addr,
   output logic [7:0]             wr_data,
   // Register read lookup
   output logic [5:0]             rd_addr,
   input  wire logic [7:0]        rd_data,
   // Direct commands
   output logic                   cmd_valid,
   output logic [5:0]             cmd_code,
   // Transmit data toward the core
   output logic                   tx_valid,
   output logic [7:0]             tx_data,
   input  wire logic              tx_ready,
   output logic                   load_ready,
   // Received data from the core
   input  wire logic              rx_valid,
   input  wire logic [7:0]        rx_data,
   output logic                   rx_pop
);

   ////////////////////////////////////////////////////////////////////////
   // Address decoding.

   function automatic logic rhsp_mapped(input logic [5:0] a);
      rhsp_mapped = (a <= MAP_LAST);
   endfunction : rhsp_mapped

   function automatic logic rhsp_writable(input logic [5:0] a);
      rhsp_writable = rhsp_mapped(a) && (a < RO_FIRST);
   endfunction : rhsp_writable

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   logic sel_s1, sel_s2;
   logic sclk_s1, sclk_s2, sclk_d;
   logic din_s1, din_s2;
   logic en_s1, en_s2;
   logic fall, rise;

   // Pins are sampled twice before use; the serial clock is oversampled
   // at more than six core cycles per serial phase.
   always_ff @(posedge clock) begin
      if (srst) begin
         sel_s1  <= 1'b0;
         sel_s2  <= 1'b0;
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_d  <= 1'b0;
         din_s1  <= 1'b0;
         din_s2  <= 1'b0;
         en_s1   <= 1'b0;
         en_s2   <= 1'b0;
      end else begin
         sel_s1  <= serial_select;
         sel_s2  <= sel_s1;
         sclk_s1 <= serial_clock;
         sclk_s2 <= sclk_s1;
         sclk_d  <= sclk_s2;
         din_s1  <= serial_in;
         din_s2  <= din_s1;
         en_s1   <= external_enable_pin;
         en_s2   <= en_s1;
      end
   end

   assign fall = sclk_d & ~sclk_s2;
   assign rise = ~sclk_d & sclk_s2;

   ////////////////////////////////////////////////////////////////////////
   // Load buffer.

   rhsp_fifo_if #(.WIDTH(`RHSP_BYTE_BITS)) load_if ();

   rhsp_fifo #(
      .WIDTH (`RHSP_BYTE_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock (clock),
      .srst  (srst),
      .f     (load_if)
   );

   assign tx_valid          = load_if.out_valid;
   assign tx_data           = load_if.out_data;
   assign load_if.out_ready = tx_ready;
   assign load_ready        = load_if.in_ready;

   ////////////////////////////////////////////////////////////////////////
   // Serial transaction engine.

   rhsp_pkg::rhsp_state_t state, next_state;
   logic [1:0]            mode, next_mode;
   logic [2:0]            bitcnt, next_bitcnt;
   rhsp_pkg::rhsp_byte_t  shin, next_shin;
   rhsp_pkg::rhsp_byte_t  shout, next_shout;
   rhsp_pkg::rhsp_addr_t  addr, next_addr;
   logic [5:0]            loads, next_loads;
   logic                  held, next_held;
   logic                  push, next_push;
   rhsp_pkg::rhsp_byte_t  push_data, next_push_data;
   logic                  next_serial_out, next_serial_out_en;
   logic                  next_wr_valid, next_cmd_valid, next_rx_pop;
   logic [5:0]            next_wr_addr, next_cmd_code;
   logic [7:0]            next_wr_data;
   logic                  reading;
   rhsp_pkg::rhsp_byte_t  full_byte, rd_byte;

   assign load_if.in_valid = push;
   assign load_if.in_data  = push_data;

   always_comb begin
      next_state         = state;
      next_mode          = mode;
      next_bitcnt        = bitcnt;
      next_shin          = shin;
      next_shout         = shout;
      next_addr          = addr;
      next_loads         = loads;
      next_held          = held;
      next_push          = 1'b0;
      next_push_data     = push_data;
      next_serial_out    = serial_out;
      next_serial_out_en = serial_out_en;
      next_wr_valid      = 1'b0;
      next_wr_addr       = wr_addr;
      next_wr_data       = wr_data;
      next_cmd_valid     = 1'b0;
      next_cmd_code      = cmd_code;
      next_rx_pop        = 1'b0;
      full_byte          = {shin[6:0], din_s2};
      reading            = (mode == `RHSP_MODE_READ) ||
                           (mode == `RHSP_MODE_FIFO && addr == `RHSP_FIFO_READ);
      rd_byte            = '0;
      if (mode == `RHSP_MODE_FIFO) begin
         rd_byte = rx_valid ? rx_data : '0;
      end else if (rhsp_mapped(addr)) begin
         rd_byte = rd_data;
      end
      if (!sel_s2) begin
         // Dropping select abandons any partial byte without effect.
         next_state         = rhsp_pkg::st_idle;
         next_bitcnt        = '0;
         next_held          = 1'b0;
         next_serial_out    = 1'b0;
         next_serial_out_en = 1'b0;
      end else begin
         case (state)
            rhsp_pkg::st_idle: begin
               next_state = rhsp_pkg::st_ctrl;
               next_loads = '0;
               next_shin  = '0;
            end
            rhsp_pkg::st_ctrl: begin
               if (fall) begin
                  next_shin   = full_byte;
                  next_bitcnt = bitcnt + 3'h1;
                  if (bitcnt == `RHSP_BIT_LAST) begin
                     next_mode  = full_byte[7:6];
                     next_addr  = full_byte[5:0];
                     next_state = rhsp_pkg::st_data;
                     if (full_byte[7:6] == `RHSP_MODE_CMD) begin
                        next_cmd_valid = 1'b1;
                        next_cmd_code  = full_byte[5:0];
                        next_state     = rhsp_pkg::st_halt;
                     end else if (full_byte[7:6] == `RHSP_MODE_FIFO &&
                                  full_byte[5:0] != `RHSP_FIFO_LOAD &&
                                  full_byte[5:0] != `RHSP_FIFO_READ) begin
                        // Mixed FIFO codes are not defined, so they are ignored.
                        next_state = rhsp_pkg::st_halt;
                     end
                  end
               end
            end
            rhsp_pkg::st_data: begin
               if (rise && reading) begin
                  next_serial_out_en = 1'b1;
                  if (bitcnt == '0) begin
                     // Unmapped addresses read as zero outside FIFO mode.
                     next_serial_out = rd_byte[7];
                     next_shout      = {rd_byte[6:0], 1'b0};
                     next_held       = (mode == `RHSP_MODE_FIFO) & rx_valid;
                  end else begin
                     next_serial_out = shout[7];
                     next_shout      = {shout[6:0], 1'b0};
                  end
               end
               if (fall) begin
                  next_shin   = full_byte;
                  next_bitcnt = bitcnt + 3'h1;
                  if (bitcnt == `RHSP_BIT_LAST) begin
                     if (mode != `RHSP_MODE_FIFO) begin
                        next_addr = addr + `RHSP_ADDR_INC;
                     end
                     if (mode == `RHSP_MODE_WRITE && rhsp_writable(addr)) begin
                        next_wr_valid = 1'b1;
                        next_wr_addr  = addr;
                        next_wr_data  = full_byte;
                     end
                     if (mode == `RHSP_MODE_FIFO && !reading) begin
                        // Bytes past the load limit or into a full buffer are lost.
                        if (loads != `RHSP_LOAD_MAX && load_if.in_ready) begin
                           next_push      = 1'b1;
                           next_push_data = full_byte;
                           next_loads     = loads + 6'h01;
                        end
                     end
                     if (reading && held) begin
                        next_rx_pop = 1'b1;
                        next_held   = 1'b0;
                     end
                  end
               end
            end
            default: begin
               next_serial_out_en = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state         <= rhsp_pkg::st_idle;
         mode          <= `RHSP_MODE_WRITE;
         bitcnt        <= '0;
         shin          <= '0;
         shout         <= '0;
         addr          <= '0;
         loads         <= '0;
         held          <= 1'b0;
         push          <= 1'b0;
         push_data     <= '0;
         serial_out    <= 1'b0;
         serial_out_en <= 1'b0;
         wr_valid      <= 1'b0;
         wr_addr       <= '0;
         wr_data       <= '0;
         cmd_valid     <= 1'b0;
         cmd_code      <= '0;
         rx_pop        <= 1'b0;
      end else begin
         state         <= next_state;
         mode          <= next_mode;
         bitcnt        <= next_bitcnt;
         shin          <= next_shin;
         shout         <= next_shout;
         addr          <= next_addr;
         loads         <= next_loads;
         held          <= next_held;
         push          <= next_push;
         push_data     <= next_push_data;
         serial_out    <= next_serial_out;
         serial_out_en <= next_serial_out_en;
         wr_valid      <= next_wr_valid;
         wr_addr       <= next_wr_addr;
         wr_data       <= next_wr_data;
         cmd_valid     <= next_cmd_valid;
         cmd_code      <= next_cmd_code;
         rx_pop        <= next_rx_pop;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Enable pin, interrupt pin and read address.

   logic next_run_enable, next_interrupt_request;
   logic [5:0] next_rd_addr;

   always_comb begin
      next_run_enable        = run_enable_bit | en_s2;
      // The port never starts a transfer; attention is only this pin.
      next_interrupt_request = irq_pending;
      next_rd_addr           = addr;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         run_enable        <= 1'b0;
         interrupt_request <= 1'b0;
         rd_addr           <= '0;
      end else begin
         run_enable        <= next_run_enable;
         interrupt_request <= next_interrupt_request;
         rd_addr           <= next_rd_addr;
      end
   end

endmodule : rhsp_port
`default_nettype wire

// >>> verification/rhsp_host_model.sv
// Host model: serial bus master paced by the core clock.
`timescale 1ns/10ps
`default_nettype none
module rhsp_host_model #(
   parameter int HALF = 8
) (
   // Pacing clock
   input wire logic  clock,
   // Serial pins
   output var logic  serial_select,
   output var logic  serial_clock,
   output var logic  serial_in,
   input  wire logic serial_out
);
   initial begin
      serial_select = 1'b0;
      serial_clock  = 1'b0;
      serial_in     = 1'b0;
   end
   ////////////////////////////////////////////////////////////
   task automatic wait_half();
      repeat (HALF) @(posedge clock);
   endtask : wait_half
   task automatic open_frame();
      serial_select <= 1'b1;
      wait_half();
   endtask : open_frame
   // Data is launched on the rising edge so that it stands still at the
   // falling edge where the port samples it. Fewer than eight bits makes a
   // cut byte on purpose.
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nbits; i--) begin
         serial_clock <= 1'b1;
         serial_in    <= tx[i];
         wait_half();
         rx[i] = serial_out;
         serial_clock <= 1'b0;
         wait_half();
      end
   endtask : xfer
   task automatic close_frame();
      wait_half();
      serial_select <= 1'b0;
      // The idle data line must not look like the last bit sent.
      serial_in <= ~serial_in;
      repeat (3) wait_half();
   endtask : close_frame
endmodule : rhsp_host_model
`default_nettype wire

// >>> verification/rhsp_port_checker.sv
// Concurrent checks on the ports of the reader host serial port.
`timescale 1ns/10ps
`default_nettype none
module rhsp_port_checker #(
   parameter logic [5:0] RO_FIRST = 6'h38
) (
   // Clock and reset
   input wire logic       clock,
   input wire logic       srst,
   // Pins and core status
   input wire logic       serial_select,
   input wire logic       serial_out_en,
   input wire logic       run_enable_bit,
   input wire logic       irq_pending,
   input wire logic       interrupt_request,
   input wire logic       run_enable,
   // Core strobes
   input wire logic       wr_valid,
   input wire logic [5:0] wr_addr,
   input wire logic       cmd_valid,
   input wire logic       rx_pop
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////
   a_oe_idle: assert property (!serial_select [*5] |-> !serial_out_en)
      else $error("output driven while deselected");
   // Any strobe this long after select fell came from a cut byte.
   a_quiet_idle: assert property (!serial_select [*8] |-> !(wr_valid || cmd_valid || rx_pop))
      else $error("strobe while deselected");
   a_wr_pulse: assert property (wr_valid |=> !wr_valid)
      else $error("write strobe longer than one cycle");
   a_wr_range: assert property (wr_valid |-> wr_addr < RO_FIRST)
      else $error("write to read-only or unmapped address");
   a_cmd_once: assert property (cmd_valid |=> !cmd_valid [*8])
      else $error("command issued twice");
   a_pop_once: assert property (rx_pop |=> !rx_pop)
      else $error("pop longer than one cycle");
   a_irq_copy: assert property (!$past(srst) |-> interrupt_request == $past(irq_pending))
      else $error("interrupt does not follow pending");
   a_run_follow: assert property ($past(run_enable_bit) && !$past(srst) |-> run_enable)
      else $error("run enable ignores its bit");
endmodule : rhsp_port_checker
bind rhsp_port rhsp_port_checker #(.RO_FIRST(RO_FIRST)) u_checker (
   .clock(clock), .srst(srst), .serial_select(serial_select), .serial_out_en(serial_out_en),
   .run_enable_bit(run_enable_bit), .irq_pending(irq_pending), .interrupt_request(interrupt_request),
   .run_enable(run_enable), .wr_valid(wr_valid), .wr_addr(wr_addr), .cmd_valid(cmd_valid), .rx_pop(rx_pop)
);
`default_nettype wire

// >>> verification/test_reader_host_serial_port.sv
// Self-checking bench for the reader host serial port.
`timescale 1ns/10ps
`default_nettype none
`include "rhsp_regs.svh"
module test_reader_host_serial_port;
   logic        clock = 1'b0, srst = 1'b1, external_enable_pin = 1'b0, run_enable_bit = 1'b0;
   logic        irq_pending = 1'b0, tx_ready = 1'b0, rx_valid = 1'b0;
   logic        serial_select, serial_clock, serial_in, serial_out, serial_out_en, interrupt_request;
   logic        run_enable, wr_valid, cmd_valid, tx_valid, load_ready, rx_pop;
   logic [5:0]  wr_addr, rd_addr, cmd_code, a;
   logic [7:0]  wr_data, tx_data, rd_data, rxb, d, rx_data = 8'h00;
   logic [15:0] expq[$];
   int          miscompares = 0, n_tests = 0, cycles = 0;
   always #5 clock = ~clock;
   // Register stand-in: each address reads back a value made from the address.
   always_comb rd_data = {2'h0, rd_addr} ^ 8'h5A;
   rhsp_port dut (
      .clock(clock), .srst(srst), .serial_select(serial_select), .serial_clock(serial_clock),
      .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
      .external_enable_pin(external_enable_pin), .interrupt_request(interrupt_request),
      .run_enable_bit(run_enable_bit), .irq_pending(irq_pending), .run_enable(run_enable),
      .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .load_ready(load_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_pop(rx_pop)
   );
   rhsp_host_model u_host (
      .clock(clock), .serial_select(serial_select), .serial_clock(serial_clock),
      .serial_in(serial_in), .serial_out(serial_out)
   );
   ////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic take(input logic [15:0] seen);
      check("event", seen, (expq.size() > 0) ? expq.pop_front() : 16'hXXXX);
   endtask : take
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   // Every core-side strobe must match the oldest expected one.
   always @(posedge clock) begin
      if (wr_valid === 1'b1) take({2'h0, wr_addr, wr_data});
      if (cmd_valid === 1'b1) take({2'h3, cmd_code, 8'h00});
      if (tx_valid === 1'b1 && tx_ready === 1'b1) take({2'h2, 6'h00, tx_data});
      if (rx_pop === 1'b1) take({2'h1, 6'h3F, 8'h00});
      cycles++;
      if (cycles > 20000) begin
         miscompares++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      d = 8'($urandom(16));
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      repeat (4) @(posedge clock);
      // The second frame runs off the top of the map and wraps to zero.
      for (int k = 0; k < 2; k++) begin
         a = k ? 6'h3E : 6'h36;
         u_host.open_frame();
         u_host.xfer({2'h0, a}, 8, rxb);
         repeat (3) begin
            d = 8'($urandom);
            if (a < `RHSP_RO_FIRST) expq.push_back({2'h0, a, d});
            u_host.xfer(d, 8, rxb);
            a = a + `RHSP_ADDR_INC;
         end
         u_host.xfer(8'hFF, 5, rxb);
         u_host.close_frame();
      end
      $display("write done");
      a = 6'h3C;
      u_host.open_frame();
      u_host.xfer({2'h1, a}, 8, rxb);
      repeat (3) begin
         u_host.xfer(8'h00, 8, rxb);
         check("read", {8'h00, rxb}, {8'h00, (a <= `RHSP_MAP_LAST) ? {2'h0, a} ^ 8'h5A : 8'h00});
         a = a + `RHSP_ADDR_INC;
      end
      check("drive", {15'h0, serial_out_en}, 16'h0001);
      u_host.close_frame();
      check("release", {15'h0, serial_out_en}, 16'h0000);
      $display("read done");
      repeat (6) begin
         a = 6'($urandom);
         expq.push_back({2'h3, a, 8'h00});
         u_host.open_frame();
         u_host.xfer({2'h3, a}, 8, rxb);
         u_host.close_frame();
      end
      $display("command done");
      // Drain is stalled, so bytes past the buffer depth are lost.
      u_host.open_frame();
      u_host.xfer(8'h80, 8, rxb);
      for (int k = 0; k < 18; k++) begin
         d = 8'($urandom);
         if (k < `RHSP_FIFO_DEPTH) expq.push_back({2'h2, 6'h00, d});
         u_host.xfer(d, 8, rxb);
      end
      u_host.xfer(8'hC3, 6, rxb);
      u_host.close_frame();
      check("full", {15'h0, load_ready}, 16'h0000);
      tx_ready <= 1'b1;
      repeat (40) @(posedge clock);
      check("empty", {15'h0, load_ready}, 16'h0001);
      $display("load done");
      // With the drain running the buffer never fills, so only the limit drops bytes.
      u_host.open_frame();
      u_host.xfer(8'h80, 8, rxb);
      for (int k = 0; k < 34; k++) begin
         d = 8'($urandom);
         if (k < `RHSP_LOAD_MAX) expq.push_back({2'h2, 6'h00, d});
         u_host.xfer(d, 8, rxb);
      end
      u_host.close_frame();
      // A FIFO code that is neither load nor read must move nothing.
      u_host.open_frame();
      u_host.xfer(8'h85, 8, rxb);
      u_host.xfer(8'h11, 8, rxb);
      u_host.close_frame();
      $display("limit done");
      rx_valid <= 1'b1;
      rx_data  <= 8'($urandom);
      for (int k = 4; k <= 8; k = k + 4) begin
         if (k == 8) expq.push_back({2'h1, 6'h3F, 8'h00});
         u_host.open_frame();
         u_host.xfer(8'hBF, 8, rxb);
         u_host.xfer(8'h00, k, rxb);
         u_host.close_frame();
      end
      check("unread", {8'h00, rxb}, {8'h00, rx_data});
      $display("fifo read done");
      for (int k = 0; k < 8; k++) begin
         {irq_pending, external_enable_pin, run_enable_bit} <= 3'(k);
         repeat (6) @(posedge clock);
         check("run", {15'h0, run_enable}, {15'h0, |k[1:0]});
         check("irq", {15'h0, interrupt_request}, {15'h0, k[2]});
      end
      $display("pins done");
      repeat (20) @(posedge clock);
      check("pending", 16'(expq.size()), 16'h0000);
      conclude();
   end
endmodule : test_reader_host_serial_port
`default_nettype wire
